// ===== hw/swp_pkg.sv
package swp_pkg;
	// Port addresses
	localparam logic [15:0] REG_SHADOW_CTL = 16'h6072;
	localparam logic [15:0] REG_HIGH_BND = 16'hc072;
	localparam logic [15:0] REG_SPLIT = 16'h5872;
	localparam logic [15:0] REG_TIMING = 16'h4072;
	// Shadow control field positions
	localparam int ONBOARD_MEM_DISABLE_LSB = 14;
	localparam int HIGH_REGION_PROTECT_EN_BIT = 13;
	localparam int WP_BIT = 12;
	localparam int PARITY_INVERT_BIT = 11;
	localparam int PAR_OFF_BIT = 10;
	localparam int SHD_LSB = 8;
	localparam int XMEM_BIT = 7;
	localparam int VB_LSB = 4;
	localparam int ROM_LSB = 2;
	localparam int MOU_LSB = 0;
	// Split register field positions
	localparam int SPLIT_SZ_LSB = 8;
	localparam int SPLIT_BASE_LSB = 2;
	// Reset values and writable masks
	localparam logic [15:0] CTL_RESET = 16'h0004;
	localparam logic [15:0] CTL_MASK = 16'hffbf;
	localparam logic [7:0] BND_RESET = 8'h00;
	localparam logic [15:0] SPLIT_RESET = 16'h0000;
	localparam logic [15:0] SPLIT_MASK = 16'hfffc;
	localparam logic [15:0] TIMING_RESET = 16'h0000;
	localparam logic [15:0] TIMING_MASK = 16'h7f7f;
	// Address map corners
	localparam logic [24:0] HOLE_START = 25'h00a0000;
	localparam logic [24:0] ONE_MEG = 25'h0100000;
	localparam logic [24:0] LIM_512K = 25'h0080000;
	localparam logic [24:0] LIM_256K = 25'h0040000;
	localparam logic [24:0] LIM_128K = 25'h0020000;
	localparam logic [24:0] SPLIT_256K = 25'h0040000;
	localparam logic [24:0] SPLIT_320K = 25'h0050000;
	localparam logic [24:0] SPLIT_384K = 25'h0060000;
	localparam logic [7:0] SEG_C = 8'h0c;
	localparam logic [7:0] SEG_E = 8'h0e;
	localparam logic [7:0] SEG_F = 8'h0f;
	localparam logic [7:0] SEG_TOP = 8'hff;
	localparam logic [6:0] TOP_128K = 7'h7f;
	// Chip-select codes
	localparam logic [4:0] CS_BOOT_ROM = 5'h00;
	localparam logic [4:0] CS_IDLE = 5'h1f;
	// Timing
	localparam int CLK_KHZ = 10000;
	localparam int BOOST_TIME_MS = 1000;
	localparam int BOOST_CYCLES = BOOST_TIME_MS * CLK_KHZ;
	localparam logic [7:0] CAL_WINDOW = 8'hff;
	typedef enum logic [1:0] {
		SHD_NONE = 2'b00,
		SHD_SYS64 = 2'b01,
		SHD_SYS128 = 2'b10,
		SHD_SYS_VID = 2'b11
	} swp_shadow_e;
	typedef enum logic [1:0] {
		ROM_128K = 2'b00,
		ROM_64K = 2'b01,
		ROM_SHARED = 2'b10,
		ROM_RSVD = 2'b11
	} swp_rom_e;
endpackage

// ===== hw/swp_sync.sv
module swp_sync
	import swp_pkg::*;
#(
	parameter int W = 7
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Raw and synchronised levels
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} swp_sync_s;
	swp_sync_s st;
	swp_sync_s next_st;

	always_comb begin
		next_st.s1 = din;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign dout = st.s2;
endmodule

// ===== hw/swp_map.sv
// How it works
// - Disable field drops on-board DRAM from 512/256/128 KB up to 640 KB.
// - High protect enable blocks writes at or above 8-bit boundary on zero-extended A23-A17.
// - BIOS protect bit refuses writes to shadowed BIOS; clear by reset.
// - Parity invert bit makes DRAM writes carry inverted parity.
// - Parity off bit disables checking, else legacy port setting rules.
// - Top 64 KB of the 16 MB space is never shadowed, always ROM.
// - Shadow field picks none, 64 KB, 128 KB or 64 KB plus video.
// - Shadow code 11 shows video shadow at C0000H instead of E0000H.
// - Video size 16/32/48/64 KB sets video shadow and ROM decode length.
// - Code 11 with extra-memory bit makes E8000H-EFFFFH plain DRAM.
// - ROM type 00 selects ROM at 0E0000H-0FFFFFH and FE0000H-FFFFFFH.
// - ROM type 01, the reset default, selects only the top 64 KB blocks.
// - ROM type 10 adds the sized video region at C0000H; 11 reserved.
// - Boot ROM select shows as zero on the five chip-select outputs.
// - Mouse activity with auto speed raises speed one second; line select.
// - Once E segment remaps to C0000H, E accesses outside extra memory go to bus, no ROM.
// - DMA strobe timing uses a delay line calibrated on the 14 MHz ref.
// - DMA row strobe starts from the active bus memory command.
// - Timing register writes take effect at once; run it from ROM.
// - Split remaps the 0A0000H hole to a 512 KB aligned destination.
module swp_map
	import swp_pkg::*;
#(
	parameter int unsigned BOOST_LEN = BOOST_CYCLES
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic NRST,
	// Register port
	input wire logic IO_WR,
	input wire logic IO_RD,
	input wire logic [15:0] IO_ADDR,
	input wire logic [15:0] IO_WDATA,
	output logic [15:0] IO_RDATA,
	// Host memory cycle
	input wire logic MEM_REQ,
	input wire logic MEM_WRITE,
	input wire logic [23:0] MEM_ADDR,
	output logic [4:0] CHIP_SEL,
	output logic DRAM_SEL,
	output logic DRAM_WR_EN,
	output logic BUS_SEL,
	output logic CYC_DONE,
	output logic [23:0] DRAM_ADDR,
	// Parity
	input wire logic PORT61_PARITY_EN,
	output logic PARITY_INVERT,
	output logic PARITY_CHECK_EN,
	// Mouse speed boost
	input wire logic AUTO_SPEED_SWITCH,
	input wire logic [2:0] MOUSE_IRQ,
	output logic SPEED_BOOST,
	// DMA strobe timing
	input wire logic DMA_ACTIVE,
	input wire logic BUS_MEMR_N,
	input wire logic BUS_MEMW_N,
	input wire logic REFERENCE_CLOCK_14M,
	output logic RAS_START,
	output logic [7:0] DELAY_TAP,
	output logic [15:0] DRAM_TIMING
);
	typedef struct packed {
		logic [15:0] ctl;
		logic [7:0] bnd;
		logic [15:0] split;
		logic [15:0] timing;
		logic [15:0] rdata;
		logic [4:0] cs;
		logic dram;
		logic dram_we;
		logic bus;
		logic done;
		logic [23:0] daddr;
		logic par_inv;
		logic par_chk;
		logic [23:0] boost;
		logic boost_on;
		logic mouse_prev;
		logic cmd_prev;
		logic ras;
		logic ref_prev;
		logic [7:0] cal_cnt;
		logic [7:0] cal_win;
		logic [7:0] tap;
	} swp_state_s;

	typedef struct packed {
		logic rom;
		logic dram;
		logic wprot;
		logic [23:0] daddr;
	} swp_dec_s;

	swp_state_s st;
	swp_state_s next_st;
	logic [6:0] sync_out;
	logic [2:0] irq_s;
	logic memr_n_s;
	logic memw_n_s;
	logic dma_s;
	logic ref_s;
	swp_dec_s dec;

	swp_sync #(
		.W(7)
	) u_sync (
		.clk(CORE_CLK),
		.nrst(NRST),
		.din({MOUSE_IRQ, BUS_MEMR_N, BUS_MEMW_N, DMA_ACTIVE,
			REFERENCE_CLOCK_14M}),
		.dout(sync_out)
	);
	assign irq_s = sync_out[6:4];
	assign memr_n_s = sync_out[3];
	assign memw_n_s = sync_out[2];
	assign dma_s = sync_out[1];
	assign ref_s = sync_out[0];

	function automatic swp_dec_s decode(input logic [23:0] a,
		input logic [15:0] ctl, input logic [7:0] bnd,
		input logic [15:0] split);
		swp_dec_s d;
		swp_shadow_e shadow_layout;
		swp_rom_e rom;
		logic [7:0] seg;
		logic [24:0] ax;
		logic [24:0] lim;
		logic [24:0] base;
		logic [24:0] off;
		logic [24:0] ssize;
		logic vid, sh, xm, ebus, rraw, hole, ldis, insp;
		shadow_layout = swp_shadow_e'(ctl[SHD_LSB +: 2]);
		rom = swp_rom_e'(ctl[ROM_LSB +: 2]);
		seg = a[23:16];
		ax = {1'b0, a};
		vid = (seg == SEG_C) && (a[15:14] <= ctl[VB_LSB +: 2]);
		sh = ((shadow_layout != SHD_NONE) && (seg == SEG_F)) ||
			((shadow_layout == SHD_SYS128) && (seg == SEG_E)) ||
			((shadow_layout == SHD_SYS_VID) && vid);
		// Extra memory in upper E segment
		xm = (shadow_layout == SHD_SYS_VID) && ctl[XMEM_BIT] && (seg == SEG_E) &&
			a[15];
		// E segment forced to expansion bus
		ebus = (seg == SEG_E) && ((shadow_layout == SHD_SYS_VID) ||
			((shadow_layout == SHD_NONE) && (rom == ROM_SHARED)));
		case (rom)
			ROM_128K: rraw = (a[23:17] == TOP_128K) || (seg == SEG_E) ||
				(seg == SEG_F);
			ROM_SHARED: rraw = (seg == SEG_TOP) || (seg == SEG_F) || vid;
			default: rraw = (seg == SEG_TOP) || (seg == SEG_F);
		endcase
		d.rom = rraw && !sh && !ebus;
		// On-board memory disable below 640 KB
		case (ctl[ONBOARD_MEM_DISABLE_LSB +: 2])
			2'b01: lim = LIM_512K;
			2'b10: lim = LIM_256K;
			2'b11: lim = LIM_128K;
			default: lim = HOLE_START;
		endcase
		ldis = (ax >= lim) && (ax < HOLE_START);
		hole = (ax >= HOLE_START) && (ax < ONE_MEG);
		// Split hole remapped to its destination
		case (split[SPLIT_SZ_LSB +: 2])
			2'b01: ssize = SPLIT_256K;
			2'b10: ssize = SPLIT_320K;
			2'b11: ssize = SPLIT_384K;
			default: ssize = '0;
		endcase
		base = {split[7:SPLIT_BASE_LSB], 19'h00000};
		off = ax - base;
		insp = (ssize != '0) && (ax >= base) && (off < ssize);
		d.dram = sh || xm || insp || (!hole && !d.rom && !ldis);
		d.daddr = insp ? 24'(HOLE_START + off) : a;
		d.wprot = (ctl[WP_BIT] && sh) ||
			(ctl[HIGH_REGION_PROTECT_EN_BIT] && ({1'b0, a[23:17]} >= bnd));
		return d;
	endfunction

	assign dec = decode(MEM_ADDR, st.ctl, st.bnd, st.split);

	always_comb begin
		logic msel;
		logic cmd;
		msel = 1'b0;
		cmd = 1'b0;
		next_st = st;
		// Register writes
		if (IO_WR) begin
			case (IO_ADDR)
				REG_SHADOW_CTL: next_st.ctl = IO_WDATA & CTL_MASK;
				REG_HIGH_BND: next_st.bnd = IO_WDATA[7:0];
				REG_SPLIT: next_st.split = IO_WDATA & SPLIT_MASK;
				REG_TIMING: next_st.timing = IO_WDATA & TIMING_MASK;
				default: next_st.timing = st.timing;
			endcase
		end
		// Register reads
		if (IO_RD) begin
			case (IO_ADDR)
				REG_SHADOW_CTL: next_st.rdata = st.ctl;
				REG_HIGH_BND: next_st.rdata = {8'h00, st.bnd};
				REG_SPLIT: next_st.rdata = st.split;
				REG_TIMING: next_st.rdata = st.timing;
				default: next_st.rdata = 16'h0000;
			endcase
		end
		next_st.cs = (MEM_REQ && dec.rom) ? CS_BOOT_ROM : CS_IDLE;
		next_st.dram = MEM_REQ && dec.dram;
		next_st.bus = MEM_REQ && !dec.dram && !dec.rom;
		next_st.dram_we = MEM_REQ && MEM_WRITE && dec.dram && !dec.wprot;
		next_st.done = MEM_REQ;
		next_st.daddr = MEM_REQ ? dec.daddr : st.daddr;
		next_st.par_inv = st.ctl[PARITY_INVERT_BIT];
		next_st.par_chk = PORT61_PARITY_EN && !st.ctl[PAR_OFF_BIT];
		// Mouse line select and one second boost
		case (st.ctl[MOU_LSB +: 2])
			2'b01: msel = irq_s[0];
			2'b10: msel = irq_s[1];
			2'b11: msel = irq_s[2];
			default: msel = 1'b0;
		endcase
		next_st.mouse_prev = msel;
		if (msel && !st.mouse_prev && AUTO_SPEED_SWITCH) begin
			next_st.boost = 24'(BOOST_LEN);
		end else if (st.boost != '0) begin
			next_st.boost = st.boost - 24'h000001;
		end
		next_st.boost_on = next_st.boost != '0;
		// Row strobe from bus memory command
		cmd = dma_s && (!memr_n_s || !memw_n_s);
		next_st.cmd_prev = cmd;
		next_st.ras = cmd && !st.cmd_prev;
		// Delay line calibration on reference edges
		next_st.ref_prev = ref_s;
		if (st.cal_win == '0) begin
			next_st.cal_win = CAL_WINDOW;
			next_st.tap = st.cal_cnt;
			next_st.cal_cnt = '0;
		end else begin
			next_st.cal_win = st.cal_win - 8'h01;
			if (ref_s && !st.ref_prev && st.cal_cnt != 8'hff) begin
				next_st.cal_cnt = st.cal_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			st <= '0;
			st.ctl <= CTL_RESET;
			st.bnd <= BND_RESET;
			st.split <= SPLIT_RESET;
			st.timing <= TIMING_RESET;
			st.cs <= CS_IDLE;
			st.cal_win <= CAL_WINDOW;
		end else begin
			st <= next_st;
		end
	end

	assign IO_RDATA = st.rdata;
	assign CHIP_SEL = st.cs;
	assign DRAM_SEL = st.dram;
	assign DRAM_WR_EN = st.dram_we;
	assign BUS_SEL = st.bus;
	assign CYC_DONE = st.done;
	assign DRAM_ADDR = st.daddr;
	assign PARITY_INVERT = st.par_inv;
	assign PARITY_CHECK_EN = st.par_chk;
	assign SPEED_BOOST = st.boost_on;
	assign RAS_START = st.ras;
	assign DELAY_TAP = st.tap;
	assign DRAM_TIMING = st.timing;

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!NRST);

	rom_top_a: assert property (
		MEM_REQ && MEM_ADDR[23:17] == TOP_128K &&
		st.ctl[ROM_LSB +: 2] == 2'b00 && !IO_WR |=> CHIP_SEL == CS_BOOT_ROM
	) else $error("top block did not select boot rom");
	rom_default_a: assert property (
		MEM_REQ && MEM_ADDR[23:16] == SEG_E &&
		st.ctl[ROM_LSB +: 2] == 2'b01 |=> CHIP_SEL != CS_BOOT_ROM
	) else $error("rom type 01 selected E segment");
	bios_protect_a: assert property (
		MEM_REQ && MEM_WRITE && MEM_ADDR[23:16] == SEG_F &&
		st.ctl[SHD_LSB +: 2] != 2'b00 && st.ctl[WP_BIT]
		|=> !DRAM_WR_EN && CYC_DONE
	) else $error("write reached protected shadow");
	high_protect_a: assert property (
		MEM_REQ && MEM_WRITE && st.ctl[HIGH_REGION_PROTECT_EN_BIT] &&
		{1'b0, MEM_ADDR[23:17]} >= st.bnd |=> !DRAM_WR_EN
	) else $error("write above boundary reached dram");
	par_invert_a: assert property (
		IO_WR && IO_ADDR == REG_SHADOW_CTL
		|=> ##1 PARITY_INVERT == $past(IO_WDATA[PARITY_INVERT_BIT], 2)
	) else $error("parity invert does not follow register");
	par_check_a: assert property (
		st.ctl[PAR_OFF_BIT] |=> !PARITY_CHECK_EN
	) else $error("parity check on while disabled");
	mem_disable_a: assert property (
		MEM_REQ && st.ctl[ONBOARD_MEM_DISABLE_LSB +: 2] == 2'b11 &&
		st.split[SPLIT_SZ_LSB +: 2] == 2'b00 &&
		MEM_ADDR >= 24'h020000 && MEM_ADDR < 24'h0a0000
		|=> BUS_SEL && !DRAM_SEL
	) else $error("disabled on-board memory still selected");
	e_to_bus_a: assert property (
		MEM_REQ && MEM_ADDR[23:16] == SEG_E && !st.ctl[XMEM_BIT] &&
		st.ctl[SHD_LSB +: 2] == 2'b11 |=> BUS_SEL && CHIP_SEL == CS_IDLE
	) else $error("remapped E segment not sent to bus");
	video_shadow_a: assert property (
		MEM_REQ && MEM_ADDR[23:14] == 10'h030 &&
		st.ctl[SHD_LSB +: 2] == 2'b11 |=> DRAM_SEL && CHIP_SEL == CS_IDLE
	) else $error("video shadow missing at C segment");
	ras_start_a: assert property (
		$rose(RAS_START) |-> $past(dma_s) &&
		(!$past(memr_n_s) || !$past(memw_n_s))
	) else $error("row strobe without bus command");
	boost_a: assert property (
		$rose(SPEED_BOOST) |-> $past(AUTO_SPEED_SWITCH) &&
		$past(st.ctl[MOU_LSB +: 2]) != 2'b00
	) else $error("speed boost without mouse trigger");
	cyc_done_a: assert property (
		MEM_REQ |=> CYC_DONE ##1 !CYC_DONE || $past(MEM_REQ)
	) else $error("memory cycle did not complete");

	cover property (MEM_REQ && MEM_WRITE && dec.wprot);
	cover property (RAS_START);
	cover property ($rose(SPEED_BOOST));
	cover property (MEM_REQ && dec.rom);
endmodule

// ===== verification/swp_host.sv
module swp_host (
	// Clock
	input wire logic clk,
	// Host memory cycle
	output logic mem_req,
	output logic mem_write,
	output logic [23:0] mem_addr,
	// Bus master commands
	output logic dma_active,
	output logic memr_n,
	output logic memw_n
);
	timeunit 1ns;
	timeprecision 10ps;
	initial begin
		mem_req = 1'b0;
		mem_write = 1'b0;
		mem_addr = 24'h000000;
		dma_active = 1'b0;
		memr_n = 1'b1;
		memw_n = 1'b1;
	end
	// One memory cycle, held over one edge
	task automatic cycle(input logic [23:0] a, input logic w);
		@(negedge clk);
		mem_req = 1'b1;
		mem_write = w;
		mem_addr = a;
		@(negedge clk);
		mem_req = 1'b0;
		mem_write = ~w;
		// Released lines show no stale address
		mem_addr = ~a;
	endtask
	// Bus master command inside an active transfer
	task automatic dma(input logic w);
		@(negedge clk);
		dma_active = 1'b1;
		repeat (2) @(negedge clk);
		memr_n = w;
		memw_n = ~w;
		repeat (6) @(negedge clk);
		memr_n = 1'b1;
		memw_n = 1'b1;
		@(negedge clk);
		dma_active = 1'b0;
	endtask
endmodule

// ===== verification/tb_top.sv
module tb_top
	import swp_pkg::*;
;
	timeunit 1ns;
	timeprecision 10ps;
	typedef struct {
		logic [4:0] cs;
		logic [2:0] dwb;
		logic chk;
		logic [23:0] ea;
	} swp_exp_s;
	logic CORE_CLK = 0, NRST = 0, IO_WR = 0, IO_RD = 0;
	logic PORT61_PARITY_EN = 0, AUTO_SPEED_SWITCH = 0;
	logic REFERENCE_CLOCK_14M = 0;
	logic [15:0] IO_ADDR = 0, IO_WDATA = 0, IO_RDATA, DRAM_TIMING;
	logic [2:0] MOUSE_IRQ = 0;
	logic MEM_REQ, MEM_WRITE, DMA_ACTIVE, BUS_MEMR_N, BUS_MEMW_N;
	logic [23:0] MEM_ADDR, DRAM_ADDR, a;
	logic [4:0] CHIP_SEL;
	logic DRAM_SEL, DRAM_WR_EN, BUS_SEL, CYC_DONE, PARITY_INVERT;
	logic PARITY_CHECK_EN, SPEED_BOOST, RAS_START;
	logic [7:0] DELAY_TAP;
	logic rd_seen = 0, req_seen = 0;
	logic [31:0] r;
	logic [23:0] lim[4] = '{24'h0a0000, 24'h080000, 24'h040000, 24'h020000};
	int n_fail = 0, checks = 0, cyc = 0, n;
	swp_exp_s e;
	swp_exp_s mq[$];
	logic [15:0] rq[$];
	always #50 CORE_CLK = ~CORE_CLK;
	always #34.92 REFERENCE_CLOCK_14M = ~REFERENCE_CLOCK_14M;
	swp_host i_host (.clk(CORE_CLK), .mem_req(MEM_REQ),
		.mem_write(MEM_WRITE), .mem_addr(MEM_ADDR), .dma_active(DMA_ACTIVE),
		.memr_n(BUS_MEMR_N), .memw_n(BUS_MEMW_N));
	swp_map #(.BOOST_LEN(20)) i_dut (.CORE_CLK(CORE_CLK), .NRST(NRST),
		.IO_WR(IO_WR), .IO_RD(IO_RD), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA),
		.IO_RDATA(IO_RDATA), .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE),
		.MEM_ADDR(MEM_ADDR), .CHIP_SEL(CHIP_SEL), .DRAM_SEL(DRAM_SEL),
		.DRAM_WR_EN(DRAM_WR_EN), .BUS_SEL(BUS_SEL), .CYC_DONE(CYC_DONE),
		.DRAM_ADDR(DRAM_ADDR), .PORT61_PARITY_EN(PORT61_PARITY_EN),
		.PARITY_INVERT(PARITY_INVERT), .PARITY_CHECK_EN(PARITY_CHECK_EN),
		.AUTO_SPEED_SWITCH(AUTO_SPEED_SWITCH), .MOUSE_IRQ(MOUSE_IRQ),
		.SPEED_BOOST(SPEED_BOOST), .DMA_ACTIVE(DMA_ACTIVE),
		.BUS_MEMR_N(BUS_MEMR_N), .BUS_MEMW_N(BUS_MEMW_N),
		.REFERENCE_CLOCK_14M(REFERENCE_CLOCK_14M), .RAS_START(RAS_START),
		.DELAY_TAP(DELAY_TAP), .DRAM_TIMING(DRAM_TIMING));
	task automatic cmp(input string s, input logic [23:0] x,
		input logic [23:0] g);
		checks++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", s, x, g);
		end
	endtask
	task automatic wr(input logic [15:0] ad, input logic [15:0] d);
		@(negedge CORE_CLK);
		IO_WR = 1'b1;
		IO_ADDR = ad;
		IO_WDATA = d;
		@(negedge CORE_CLK);
		IO_WR = 1'b0;
	endtask
	task automatic rd(input logic [15:0] ad, input logic [15:0] x);
		rq.push_back(x);
		@(negedge CORE_CLK);
		IO_RD = 1'b1;
		IO_ADDR = ad;
		@(negedge CORE_CLK);
		IO_RD = 1'b0;
	endtask
	task automatic mem(input logic [23:0] ad, input logic w,
		input logic [4:0] cs, input logic [2:0] dwb, input logic chk);
		mq.push_back('{cs, dwb, chk, ad});
		i_host.cycle(ad, w);
	endtask
	task automatic summarize;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Cycle counter and hang cut-off
	always @(posedge CORE_CLK) begin
		rd_seen <= IO_RD;
		req_seen <= MEM_REQ;
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_fail++;
			summarize;
		end
	end
	// Result watcher, one cycle after each request
	always @(negedge CORE_CLK) begin
		if (rd_seen && rq.size() > 0)
			cmp("rdata", rq.pop_front(), IO_RDATA);
		if (req_seen && mq.size() > 0) begin
			e = mq.pop_front();
			cmp("done", 24'h1, CYC_DONE);
			cmp("chip_sel", e.cs, CHIP_SEL);
			cmp("wr_en", e.dwb[1], DRAM_WR_EN);
			if (e.chk) begin
				cmp("dram_sel", e.dwb[2], DRAM_SEL);
				cmp("bus_sel", e.dwb[0], BUS_SEL);
				cmp("dram_addr", e.ea, DRAM_ADDR);
			end
		end
	end
	initial begin
		void'($urandom(32'h35ab));
		repeat (5) @(negedge CORE_CLK);
		NRST = 1'b1;
		rd(REG_SHADOW_CTL, CTL_RESET);
		rd(REG_HIGH_BND, 16'h0000);
		rd(16'h7072, 16'h0000);
		r = $urandom;
		wr(REG_SHADOW_CTL, r[15:0]);
		rd(REG_SHADOW_CTL, r[15:0] & CTL_MASK);
		wr(REG_SHADOW_CTL, CTL_RESET);
		mem(24'h0f0000, 0, CS_BOOT_ROM, 3'b000, 0);
		mem(24'hff0000, 0, CS_BOOT_ROM, 3'b000, 0);
		mem(24'hfe0000, 0, CS_IDLE, 3'b000, 0);
		mem(24'h0e0000, 0, CS_IDLE, 3'b001, 1);
		wr(REG_SHADOW_CTL, 16'h0000);
		mem(24'h0e0000, 0, CS_BOOT_ROM, 3'b000, 0);
		mem(24'hfe0000, 0, CS_BOOT_ROM, 3'b000, 0);
		for (n = 0; n < 4; n++) begin
			wr(REG_SHADOW_CTL, 16'h0008 | 16'(n << 4));
			mem(24'h0c0000 + 24'(n * 16'h4000), 0, CS_BOOT_ROM, 0, 0);
			if (n < 3)
				mem(24'h0c4000 + 24'(n * 16'h4000), 0, CS_IDLE, 1, 1);
		end
		mem(24'h0e0000, 0, CS_IDLE, 3'b001, 1);
		mem(24'h0f0000, 0, CS_BOOT_ROM, 3'b000, 0);
		for (n = 0; n < 4; n++) begin
			wr(REG_SHADOW_CTL, 16'(n << 14));
			mem(lim[n] - 1, 1, CS_IDLE, 3'b110, 1);
			mem(lim[n], 0, CS_IDLE, 3'b001, 1);
		end
		wr(REG_SPLIT, 16'h0110);
		mq.push_back('{CS_IDLE, 3'b110, 1'b1, 24'h0a0004});
		i_host.cycle(24'h200004, 1'b1);
		wr(REG_SHADOW_CTL, 16'h1104);
		mem(24'h0f0000, 1, CS_IDLE, 3'b100, 1);
		mem(24'h0f0000, 0, CS_IDLE, 3'b100, 1);
		mem(24'hff0000, 0, CS_BOOT_ROM, 3'b000, 0);
		wr(REG_SHADOW_CTL, 16'h0104);
		mem(24'h0f0000, 1, CS_IDLE, 3'b110, 1);
		wr(REG_SHADOW_CTL, 16'h0204);
		mem(24'h0e0000, 0, CS_IDLE, 3'b100, 1);
		wr(REG_SHADOW_CTL, 16'h0304);
		mem(24'h0c0000, 0, CS_IDLE, 3'b100, 1);
		mem(24'h0e8000, 0, CS_IDLE, 3'b001, 1);
		wr(REG_SHADOW_CTL, 16'h0384);
		mem(24'h0e8000, 1, CS_IDLE, 3'b110, 1);
		wr(REG_HIGH_BND, 16'h0010);
		wr(REG_SHADOW_CTL, 16'h2004);
		mem(24'h300000, 1, CS_IDLE, 3'b000, 0);
		for (n = 0; n < 4; n++) begin
			a = 24'($urandom % 32'h0a0000);
			mem(a, 1, CS_IDLE, 3'b110, 1);
		end
		for (n = 0; n < 8; n++) begin
			wr(REG_SHADOW_CTL, 16'h0004 | (16'(n[1:0]) << 10));
			PORT61_PARITY_EN = n[2];
			repeat (3) @(negedge CORE_CLK);
			cmp("par_inv", n[1], PARITY_INVERT);
			cmp("par_chk", n[2] & ~n[0], PARITY_CHECK_EN);
		end
		wr(REG_TIMING, 16'hffff);
		@(negedge CORE_CLK);
		cmp("timing", TIMING_MASK, DRAM_TIMING);
		rd(REG_TIMING, TIMING_MASK);
		AUTO_SPEED_SWITCH = 1'b1;
		for (int k = 0; k < 4; k++) begin
			// Quiet line first, so the select change makes no edge
			MOUSE_IRQ = 3'b000;
			wr(REG_SHADOW_CTL, 16'h0004 | 16'(k));
			repeat (5) @(negedge CORE_CLK);
			MOUSE_IRQ = (k == 0) ? 3'b111 : 3'(1 << (k - 1));
			n = 0;
			repeat (40) @(negedge CORE_CLK) n += SPEED_BOOST;
			cmp("boost", (k == 0) ? 0 : 20, n);
		end
		for (int k = 0; k < 2; k++) begin
			n = 0;
			fork
				i_host.dma(k[0]);
				repeat (12) @(negedge CORE_CLK) n += RAS_START;
			join
			cmp("ras_start", 1, n);
		end
		// Wait past two whole 256-cycle windows, so the tap holds a full window's count
		repeat (600) @(negedge CORE_CLK);
		// Reference aliases to about 4.3 MHz at the core rate
		cmp("delay_tap", 1, DELAY_TAP inside {8'h6e, 8'h6f});
		cmp("pending", 0, mq.size());
		summarize;
	end
endmodule
